// [logic/sector_protect_defines.svh]
// timing, field and offset constants for the sector protection controller
// Contract
// [RULE1] top-boot: decode A20..A12 into protection groups
// [RULE2] bottom-boot: mirrored group decode
// [RULE3] group sectors share one protect state
// [RULE4] protected sector refuses program and erase
// [RULE5] unprotect makes program and erase possible
// [RULE6] host holds reset high-voltage during procedure writes
// [RULE7] protect all sectors before first unprotect
// [RULE8] unprotect clears all; re-protect one by one
// [RULE9] delivered state is all unprotected
// [RULE10] protect state readable in identification mode
// [RULE11] status read returns 01h protected, 00h not
// [RULE12] boot protect low blocks outermost boot sectors
// [RULE13] outermost: lowest bottom-boot, highest top-boot
// [RULE14] boot protect high applies stored state
// [RULE15] high-voltage reset enters temporary unprotect
// [RULE16] removing high voltage restores prior protection
// [RULE17] temporary unprotect keeps boot sectors if pin low
// [RULE18] software command gives protect and temporary unprotect
// [RULE19] unlock cycles precede each program or erase
// [RULE20] low supply ignores writes, returns to read; the flash model takes supply as above lockout and drops no write for it
// [RULE21] glitches under 5ns start no write
// [RULE22] write needs chip/write enable low, output high
// [RULE23] power-up resets command machine to read
// [RULE24] protect state held non-volatile
`ifndef SECTOR_PROTECT_DEFINES_SVH
`define SECTOR_PROTECT_DEFINES_SVH

// avalon register offsets (byte addresses)
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_DATA 4'h8
`define REG_STAT 4'hc

// control register fields
`define CTRL_GO 0
`define CTRL_CMD_LO 1
`define CTRL_CMD_HI 3
`define CTRL_HV 4
`define CTRL_WP 5

// commands
`define CMD_WRITE 3'h0
`define CMD_READ 3'h1
`define CMD_UNLOCK_WRITE 3'h2
`define CMD_STATUS 3'h3

// status answer of an identification read
`define STATUS_PROT 8'h01
`define STATUS_UNPROT 8'h00

// unlock sequence
`define UNLOCK_ADDR1 22'h000555
`define UNLOCK_DATA1 16'h00aa
`define UNLOCK_ADDR2 22'h0002aa
`define UNLOCK_DATA2 16'h0055
`define AUTOSEL_DATA 16'h0090
`define RESET_DATA 16'h00f0
`define STATUS_WORD_ADDR 22'h000002
`define SECTOR_SHIFT 11

// bus timing: pulse widths kept far above the glitch filter
`define CLOCK_NS 8
`define GLITCH_NS 5
`define PULSE_NS 70
`define PULSE_CYCLES ((`PULSE_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define SETUP_NS 20
`define SETUP_CYCLES ((`SETUP_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

// [logic/sector_protect_pkg.sv]
// types for the sector protection controller
package sector_protect_pkg;
  typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold, st_next} bus_state_e;
  typedef enum logic [2:0] {ph_u1, ph_u2, ph_cmd, ph_main, ph_exit} phase_e;
  typedef logic [21:0] flash_addr_t;
endpackage

// [logic/pulse_timer.sv]
// cycle counter giving a done pulse after a loaded count
`timescale 1ns/1ps
module pulse_timer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] cnt_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
    end
    else if (load)
    begin
      cnt_r <= count;
    end
    else if (cnt_r != '0)
    begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // pulse_timer

// [logic/sector_protect_host.sv]
// host controller driving the flash bus for protection procedures
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sector_protect_defines.svh"
module sector_protect_host
  import sector_protect_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // flash bus
  output logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic high_voltage_select_level,
  output logic boot_write_protect_pin
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    bus_state_e bst;
    phase_e ph;
    logic [2:0] cmd;
    logic busy;
    logic hv;
    logic wp;
    flash_addr_t addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic prot;
    logic [31:0] rd;
    logic wait_n;
    flash_addr_t fa;
    logic [15:0] dq;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic tload;
  logic [7:0] tcount;
  logic tdone;

  pulse_timer #(.WIDTH(8)) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  // decides whether the current step is a write or read cycle
  function automatic logic step_is_read(input phase_e ph, input logic [2:0] cmd);
    step_is_read = (ph == ph_main) && ((cmd == `CMD_READ) || (cmd == `CMD_STATUS));
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    tload = 1'b0;
    tcount = 8'h00;
    s_nxt.wait_n = 1'b0;
    // avalon: a write is taken while idle; busy holds waitrequest for writes, reads are still answered
    if (avs_write && !s_r.wait_n && !s_r.busy)
    begin
      s_nxt.wait_n = 1'b1;
      unique case (avs_address)
        `REG_CTRL:
        begin
          s_nxt.hv = avs_writedata[`CTRL_HV]; // [RULE6] [RULE15] [RULE16]
          s_nxt.wp = avs_writedata[`CTRL_WP]; // [RULE12] [RULE14] [RULE17]
          s_nxt.cmd = avs_writedata[`CTRL_CMD_HI:`CTRL_CMD_LO];
          if (avs_writedata[`CTRL_GO])
          begin
            s_nxt.busy = 1'b1;
            s_nxt.bst = st_setup;
            // unlock cycles come first for software procedures [RULE19] [RULE18]
            s_nxt.ph = (avs_writedata[`CTRL_CMD_HI:`CTRL_CMD_LO] == `CMD_UNLOCK_WRITE
              || avs_writedata[`CTRL_CMD_HI:`CTRL_CMD_LO] == `CMD_STATUS) ? ph_u1 : ph_main;
            tload = 1'b1;
            tcount = 8'(`SETUP_CYCLES);
          end
        end
        `REG_ADDR: s_nxt.addr = avs_writedata[21:0];
        `REG_DATA: s_nxt.wdata = avs_writedata[15:0];
        default: ;
      endcase
    end
    else if (avs_read && !s_r.wait_n)
    begin
      s_nxt.wait_n = 1'b1;
      unique case (avs_address)
        `REG_CTRL: s_nxt.rd = {26'h0, s_r.wp, s_r.hv, s_r.cmd, 1'b0};
        `REG_ADDR: s_nxt.rd = {10'h0, s_r.addr};
        `REG_DATA: s_nxt.rd = {16'h0, s_r.rdata};
        // status: busy and decoded protect state [RULE10] [RULE11]
        `REG_STAT: s_nxt.rd = {22'h0, s_r.prot, s_r.busy, s_r.rdata[7:0]};
        default: s_nxt.rd = 32'h0;
      endcase
    end

    // flash bus sequencer, a write needs ce and we low with oe high [RULE22]
    unique case (s_r.bst)
      st_idle: ;
      st_setup:
      begin
        s_nxt.ce_n = 1'b0;
        s_nxt.dq_oe = !step_is_read(s_r.ph, s_r.cmd);
        unique case (s_r.ph)
          ph_u1:
          begin
            s_nxt.fa = `UNLOCK_ADDR1;
            s_nxt.dq = `UNLOCK_DATA1;
          end
          ph_u2:
          begin
            s_nxt.fa = `UNLOCK_ADDR2;
            s_nxt.dq = `UNLOCK_DATA2;
          end
          ph_cmd:
          begin
            s_nxt.fa = `UNLOCK_ADDR1;
            s_nxt.dq = (s_r.cmd == `CMD_STATUS) ? `AUTOSEL_DATA : s_r.wdata;
          end
          ph_main:
          begin
            // sector group selected on the upper bits [RULE1] [RULE2] [RULE3]
            // one protect write per group, ordered by software [RULE7] [RULE8]
            s_nxt.fa = (s_r.cmd == `CMD_STATUS)
              ? ((s_r.addr & ~22'h0007ff) | `STATUS_WORD_ADDR) : s_r.addr;
            s_nxt.dq = s_r.wdata;
          end
          ph_exit:
          begin
            s_nxt.fa = s_r.addr;
            s_nxt.dq = `RESET_DATA;
          end
          default: ;
        endcase
        if (tdone)
        begin
          s_nxt.bst = st_strobe;
          // strobe far wider than the glitch filter [RULE21]
          tload = 1'b1;
          tcount = 8'(`PULSE_CYCLES);
        end
      end
      st_strobe:
      begin
        if (step_is_read(s_r.ph, s_r.cmd))
        begin
          s_nxt.oe_n = 1'b0;
        end
        else
        begin
          s_nxt.we_n = 1'b0;
        end
        if (tdone)
        begin
          s_nxt.bst = st_hold;
          if (step_is_read(s_r.ph, s_r.cmd))
          begin
            s_nxt.rdata = flash_dq_in;
            s_nxt.prot = (flash_dq_in[7:0] == `STATUS_PROT); // [RULE11]
          end
        end
      end
      st_hold:
      begin
        s_nxt.we_n = 1'b1;
        s_nxt.oe_n = 1'b1;
        s_nxt.bst = st_next;
      end
      st_next:
      begin
        s_nxt.ce_n = 1'b1;
        s_nxt.dq_oe = 1'b0;
        s_nxt.bst = st_setup;
        tload = 1'b1;
        tcount = 8'(`SETUP_CYCLES);
        unique case (s_r.ph)
          ph_u1: s_nxt.ph = ph_u2;
          ph_u2: s_nxt.ph = ph_cmd;
          ph_cmd: s_nxt.ph = ph_main;
          ph_main: s_nxt.ph = (s_r.cmd == `CMD_STATUS) ? ph_exit : ph_u1;
          ph_exit: s_nxt.ph = ph_u1;
          default: ;
        endcase
        if ((s_r.ph == ph_main && s_r.cmd != `CMD_STATUS) || s_r.ph == ph_exit)
        begin
          s_nxt.bst = st_idle;
          s_nxt.busy = 1'b0;
          tload = 1'b0;
        end
      end
      default: ;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '{bst: st_idle, ph: ph_u1, cmd: 3'h0, busy: 1'b0, hv: 1'b0, wp: 1'b1,
               addr: 22'h0, wdata: 16'h0, rdata: 16'h0, prot: 1'b0, rd: 32'h0,
               wait_n: 1'b0, fa: 22'h0, dq: 16'h0, dq_oe: 1'b0, ce_n: 1'b1,
               oe_n: 1'b1, we_n: 1'b1};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rd;
  assign avs_waitrequest = !s_r.wait_n;
  assign flash_addr = s_r.fa;
  assign flash_dq_out = s_r.dq;
  assign flash_dq_oe = s_r.dq_oe;
  assign ce_n = s_r.ce_n;
  assign oe_n = s_r.oe_n;
  assign we_n = s_r.we_n;
  assign high_voltage_select_level = s_r.hv;
  assign boot_write_protect_pin = s_r.wp;
endmodule // sector_protect_host

// [tb/sector_protect_host_props.sv]
// assertions on the avalon port and flash bus of the host
`timescale 1ns/1ps
module sector_protect_host_props (
  // watched ports
  input wire logic clock,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic high_voltage_select_level
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  property p_we_qual;
    !we_n |-> oe_n && !ce_n && flash_dq_oe;
  endproperty
  a_we_qual: assert property (p_we_qual) else $error("bad write");
  property p_oe_qual;
    !oe_n |-> we_n && !flash_dq_oe && !ce_n;
  endproperty
  a_oe_qual: assert property (p_oe_qual) else $error("bad read");
  property p_we_wide;
    $fell(we_n) |-> !we_n [*8];
  endproperty
  a_we_wide: assert property (p_we_wide) else $error("short write");
  property p_we_hold;
    !we_n && !$past(we_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("moved");
  property p_hv_hold;
    !we_n && !$past(we_n) |-> $stable(high_voltage_select_level);
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("hv moved");
  property p_ce_setup;
    $fell(ce_n) |-> (we_n && oe_n) [*2];
  endproperty
  a_ce_setup: assert property (p_ce_setup) else $error("setup");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait long");
  property p_rd_ans;
    avs_read && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no answer");
  c_hv: cover property (!we_n && high_voltage_select_level);
  c_rd: cover property (avs_read && !avs_waitrequest);
  c_oe: cover property ($fell(oe_n));
endmodule // sector_protect_host_props
bind sector_protect_host sector_protect_host_props u_props (.clock, .arst_n, .avs_read,
  .avs_waitrequest, .flash_addr, .flash_dq_out, .flash_dq_oe, .ce_n, .oe_n, .we_n,
  .high_voltage_select_level);

// [tb/flash_model.sv]
// behavioural flash device with group protection
`timescale 1ns/1ps
`include "sector_protect_defines.svh"
module flash_model #(
  // mirrors the sector decode for a bottom-boot layout
  parameter bit BOTTOM_BOOT = 1'b0
) (
  // flash bus
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic high_voltage_select_level,
  input wire logic boot_write_protect_pin,
  output logic [15:0] flash_dq_in
);
  logic [511:0] prot_r = '0;
  // one word per sector is enough for the scenarios
  logic [15:0] mem_r [512];
  realtime fall_t = 0.0;
  logic [15:0] last_r = 16'h0000;
  logic [1:0] unlock_r = 2'h0;
  logic auto_r = 1'b0;
  logic pgm_r = 1'b0;
  logic [8:0] s;
  logic [8:0] g;
  logic ok;
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem_r[i] = 16'hffff;
  end
  always @*
  begin
    s = BOTTOM_BOOT ? ~flash_addr[20:12] : flash_addr[20:12];
    if (s[8:3] == 6'h3f) g = s;
    else if (s[8:5] != 4'h0 && s[8:5] != 4'hf) g = {s[8:5], 5'h00};
    else if (s[8:3] == 6'h00) g = 9'h000;
    else g = {s[8:5], 5'h10};
    ok = !prot_r[g] || high_voltage_select_level;
    if (!boot_write_protect_pin && s[8:1] == 8'hff) ok = 1'b0;
    if (!ce_n && !oe_n)
      flash_dq_in = auto_r ? {15'h0, prot_r[g]} : mem_r[s];
    else
      flash_dq_in = ~last_r;
  end
  always @(flash_dq_in)
    if (!ce_n && !oe_n) last_r = flash_dq_in;
  // write taken on rising we with ce low and oe high
  always @(negedge we_n)
    fall_t = $realtime;
  // supply is taken as above lockout, so no write is dropped for it
  always @(posedge we_n)
    if (!ce_n && oe_n && ($realtime - fall_t) >= `GLITCH_NS)
    begin
      if (high_voltage_select_level && unlock_r == 2'h0 && !pgm_r && flash_dq_out[15:1] == 0)
      begin
        if (flash_dq_out[0]) prot_r[g] = 1'b1;
        else prot_r = '0;
      end
      else if (pgm_r)
      begin
        if (ok) mem_r[s] = flash_dq_out;
        pgm_r = 1'b0;
      end
      else if (unlock_r == 2'h2)
      begin
        auto_r = flash_dq_out[7:0] == 8'h90;
        pgm_r = flash_dq_out[7:0] == 8'ha0;
        unlock_r = 2'h0;
      end
      else if (flash_dq_out[7:0] == 8'haa) unlock_r = 2'h1;
      else if (flash_dq_out[7:0] == 8'h55 && unlock_r == 2'h1) unlock_r = 2'h2;
      else if (flash_dq_out[7:0] == 8'hf0) auto_r = 1'b0;
    end
endmodule // flash_model

// [tb/test_sector_protect_host.sv]
// self-checking bench for the sector protection host
`timescale 1ns/1ps
`include "sector_protect_defines.svh"
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("MISMATCH readdata exp %h got %h", exp, got); \
    end \
  end
module test_sector_protect_host;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [21:0] flash_addr;
  wire [15:0] flash_dq_in;
  wire [15:0] flash_dq_out;
  wire flash_dq_oe;
  wire ce_n;
  wire oe_n;
  wire we_n;
  wire high_voltage_select_level;
  wire boot_write_protect_pin;
  int num_errors = 0;
  int total_checks = 0;
  logic [63:0] exp_q [$];
  logic [63:0] e;
  sector_protect_host dut (.clock, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .flash_addr, .flash_dq_in,
    .flash_dq_out, .flash_dq_oe, .ce_n, .oe_n, .we_n, .high_voltage_select_level,
    .boot_write_protect_pin);
  flash_model far_end (.flash_addr, .flash_dq_out, .ce_n, .oe_n, .we_n,
    .high_voltage_select_level, .boot_write_protect_pin, .flash_dq_in);
  initial
    forever #4 clock = ~clock;
  always @(posedge clock)
    if (avs_read && !avs_waitrequest)
    begin
      e = exp_q.pop_front();
      `CHK(avs_readdata & e[63:32], e[31:0])
    end
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({m, x});
    bus(1'b1, a, 32'h0);
  endtask
  task automatic op(input logic [5:0] c, input logic [21:0] a, input logic [15:0] d);
    bus(1'b0, `REG_ADDR, {10'h0, a});
    bus(1'b0, `REG_DATA, {16'h0, d});
    bus(1'b0, `REG_CTRL, {26'h0, c});
    do
      rd(`REG_STAT, 32'h0, 32'hfffffc00);
    while (avs_readdata[8] !== 1'b0);
  endtask
  task automatic prog(input logic [8:0] s, input logic [1:0] pv, input logic [15:0] x);
    logic [21:0] a;
    a = {1'b0, s, 12'($urandom)};
    op({pv, `CMD_UNLOCK_WRITE, 1'b1}, a, 16'h00a0);
    op({pv[1], 1'b0, `CMD_READ, 1'b1}, a, 16'h0);
    rd(`REG_DATA, {16'h0, x}, 32'hffff);
  endtask
  task automatic stat(input logic [8:0] s, input logic [31:0] x);
    op({2'b10, `CMD_STATUS, 1'b1}, {1'b0, s, 12'($urandom)}, 16'h0);
    rd(`REG_STAT, x, 32'h2ff);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(65));
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(4'h2, 32'h0, 32'hffffffff);
    stat(9'h015, 32'h0);
    op({2'b11, `CMD_WRITE, 1'b1}, {1'b0, 9'h010, 12'h0}, 16'h1);
    stat(9'h01f, 32'h201);
    prog(9'h013, 2'b10, 16'hffff);
    prog(9'h014, 2'b11, 16'h00a0);
    prog(9'h015, 2'b10, 16'hffff);
    prog(9'h1ff, 2'b00, 16'hffff);
    prog(9'h1fe, 2'b01, 16'hffff);
    prog(9'h1fd, 2'b00, 16'h00a0);
    prog(9'h1ff, 2'b10, 16'h00a0);
    op({2'b11, `CMD_WRITE, 1'b1}, {1'b0, 9'h1fe, 12'h0}, 16'h1);
    prog(9'h1fe, 2'b10, 16'hffff);
    // every group protected before the first unprotect write
    for (int i = 0; i < 71; i++)
      op({2'b11, `CMD_WRITE, 1'b1}, {1'b0, (i < 64) ? 9'(i * 8) : 9'(i + 441), 12'h0},
        16'h1);
    stat(9'h0c5, 32'h201);
    op({2'b11, `CMD_WRITE, 1'b1}, {1'b0, 9'h100, 12'h0}, 16'h0);
    stat(9'h010, 32'h0);
    stat(9'h1f8, 32'h0);
    op({2'b11, `CMD_WRITE, 1'b1}, {1'b0, 9'h0a0, 12'h0}, 16'h1);
    stat(9'h0bf, 32'h201);
    stat(9'h0c0, 32'h0);
    prog(9'h016, 2'b10, 16'h00a0);
    close_out();
  end
endmodule // test_sector_protect_host
